// File: src/bps_defs.svh
// Purpose: Constants of the buck protection sequencer
// Assumes: 200 MHz system clock, 4 us protection timebase
// Notes:   Times are kept in their own unit; counts derive from them
`ifndef BPS_DEFS_SVH
`define BPS_DEFS_SVH

// Clock and timebase
`define BPS_CLK_NS       5
`define BPS_TICK_NS      4000
`define BPS_TICK_CYC     (`BPS_TICK_NS / `BPS_CLK_NS)
`define BPS_US2TICK(us)  ((((us) * 1000) + `BPS_TICK_NS - 1) / `BPS_TICK_NS)

// Power-good delays
`define BPS_PG_ON_US     1000
`define BPS_PG_ON_TICKS  `BPS_US2TICK(`BPS_PG_ON_US)
`define BPS_PG_OFF_NS    2000
`define BPS_PG_OFF_CYC   (`BPS_PG_OFF_NS / `BPS_CLK_NS)

// Undervoltage timing
`define BPS_UV_DLY_US    1000
`define BPS_UV_DLY_TICKS `BPS_US2TICK(`BPS_UV_DLY_US)
`define BPS_UV_EN_US     1500
`define BPS_UV_EN_TICKS  `BPS_US2TICK(`BPS_UV_EN_US)

// Soft-start ramp times
`define BPS_SS0_US       700
`define BPS_SS1_US       1400
`define BPS_SS2_US       2800
`define BPS_SS3_US       5600

// Hiccup timing
`define BPS_HIC_BASE     257
`define BPS_HIC_N0       8
`define BPS_HIC_REPS     7

// Widths and reset values
`define BPS_TW           14
`define BPS_ZC_W         4
`define BPS_ZC_CODE_RST  4'h4

`endif

// File: src/bps_pkg.sv
// Purpose: Types shared by the buck protection sequencer
// Assumes: bps_defs.svh holds the numbers
// Notes:   Sense bundle groups all asynchronous comparator flags
package bps_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    BPS_IDLE,
    BPS_SOFT,
    BPS_RUN,
    BPS_OVCLAMP,
    BPS_UVOFF,
    BPS_LATCHED
  } bps_state_t;

  // Comparator flags and straps from the analog side
  typedef struct packed {
    logic       enable;
    logic       bias_lockout;
    logic       over_temp;
    logic       undervoltage_protect;
    logic       overvoltage_protect;
    logic       backup_overvoltage_sense;
    logic       overcurrent_protect;
    logic       zero_cross;
    logic       win_good;
    logic       win_bad;
    logic       sw_late;
    logic       sw_early;
    logic       skip_mode;
    logic [1:0] ss_sel;
  } bps_sense_t;

  // Requests from the on-time modulator
  typedef struct packed {
    logic hs_req;
    logic ls_req;
  } bps_mod_t;

  // Drive outputs towards the power stage
  typedef struct packed {
    logic hs_drive;
    logic ls_drive;
    logic discharge;
  } bps_gate_t;

endpackage

// File: src/bps_zc_adapt.sv
// Purpose: Adaptive zero-crossing retiming for skip mode
// Assumes: Inputs already synchronised to clk_sys
// Notes:   Delay code walks at most one step per off period
`timescale 1ns/1ps
`include "bps_defs.svh"
module bps_zc_adapt (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  // Control
  input  wire logic                 skip_active,
  input  wire logic                 zc_seen,
  input  wire logic                 hs_on,
  // Timing judgement from switch node
  input  wire logic                 sw_late,
  input  wire logic                 sw_early,
  // Results
  output logic                      zc_hold,
  output logic [`BPS_ZC_W-1:0]      zc_code
);
  logic                 zc_prev;
  logic                 pend;
  logic [`BPS_ZC_W-1:0] dly_cnt;
  logic                 hs_prev;
  logic                 saw_late;
  logic                 saw_early;
  logic                 zc_rise;
  logic                 off_end;

  assign zc_rise = zc_seen & ~zc_prev;
  assign off_end = hs_on & ~hs_prev;

  // Edge history
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      zc_prev <= 1'b0;
      hs_prev <= 1'b0;
    end
    else
    begin
      zc_prev <= zc_seen;
      hs_prev <= hs_on;
    end
  end

  // Retimed low-side cut after zero current
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      zc_hold <= 1'b0;
      pend    <= 1'b0;
      dly_cnt <= '0;
    end
    else if (hs_on || !skip_active)
    begin
      zc_hold <= 1'b0;
      pend    <= 1'b0;
    end
    else if (zc_rise && !zc_hold && !pend)
    begin
      zc_hold <= (zc_code == '0);
      pend    <= (zc_code != '0);
      dly_cnt <= '0;
    end
    else if (pend)
    begin
      dly_cnt <= dly_cnt + 1'b1;
      if (dly_cnt == zc_code - 1'b1)
      begin
        zc_hold <= 1'b1;
        pend    <= 1'b0;
      end
    end
  end

  // Judge each skip off period, step the delay code
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      saw_late  <= 1'b0;
      saw_early <= 1'b0;
      zc_code   <= `BPS_ZC_CODE_RST;
    end
    else if (off_end)
    begin
      saw_late  <= 1'b0;
      saw_early <= 1'b0;
      if (saw_late && zc_code != '0)
        zc_code <= zc_code - 1'b1;
      else if (saw_early && !saw_late && zc_code != '1)
        zc_code <= zc_code + 1'b1;
    end
    else if (zc_hold)
    begin
      saw_late  <= saw_late | sw_late;
      saw_early <= saw_early | sw_early;
    end
  end

endmodule

// File: src/bps_sequencer.sv
// Purpose: Fault supervision and power-good sequencing of a buck stage
// Assumes: Comparator flags are asynchronous; modulator requests on clk_sys
// Notes:   Protection timing runs on one 4 us tick enable, except the power-good drop timer on clk_sys cycles
`timescale 1ns/1ps
`include "bps_defs.svh"
module bps_sequencer #(
  parameter int P_TICK_CYC = `BPS_TICK_CYC
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  // Analog flags and straps
  input  wire bps_pkg::bps_sense_t    sense_in,
  // Modulator requests
  input  wire bps_pkg::bps_mod_t      mod_req,
  // Power stage drives
  output bps_pkg::bps_gate_t          gate,
  // Open-drain power-good pin
  input  wire logic                   power_ok_out_i,
  output logic                        power_ok_out_o,
  output logic                        power_ok_out_oe,
  // Status
  output bps_pkg::bps_state_t         state,
  output logic                        soft_start_done,
  output logic                        uv_armed,
  output logic                        ovp_latched,
  output logic [`BPS_ZC_W-1:0]        zc_code
);
  import bps_pkg::*;

  bps_sense_t           sense_meta;
  bps_sense_t           sense;
  logic [15:0]          tick_cnt;
  logic                 tick;
  bps_state_t           next_state;
  logic [`BPS_TW-1:0]   tmr;
  logic [2:0]           reps;
  logic [1:0]           ss_sel_q;
  logic                 rov_src;
  logic [`BPS_TW-1:0]   ss_ticks;
  logic [`BPS_TW-1:0]   hic_wait;
  logic                 shut;
  logic                 hot;
  logic                 ov_any;
  logic [`BPS_TW-1:0]   uv_arm_cnt;
  logic [`BPS_TW-1:0]   uv_cnt;
  logic                 uv_cond;
  logic                 uv_trip;
  logic [`BPS_TW-1:0]   pg_on_cnt;
  logic [`BPS_TW-1:0]   pg_off_cnt;
  logic                 power_good;
  logic                 en_prev;
  logic                 run_ok;
  logic                 next_hs;
  logic                 next_ls;
  logic                 zc_hold;
  logic                 skip_active;

  // Two-stage synchroniser for every analog flag
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sense_meta <= '0;
      sense      <= '0;
    end
    else
    begin
      sense_meta <= sense_in;
      sense      <= sense_meta;
    end
  end

  // Common 4 us timebase
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end
    else if (tick_cnt == 16'(P_TICK_CYC - 1))
    begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end

  // Soft-start length from the captured selection
  always_comb
  begin
    case (ss_sel_q)
      2'h0:    ss_ticks = `BPS_TW'(`BPS_US2TICK(`BPS_SS0_US));
      2'h1:    ss_ticks = `BPS_TW'(`BPS_US2TICK(`BPS_SS1_US));
      2'h2:    ss_ticks = `BPS_TW'(`BPS_US2TICK(`BPS_SS2_US));
      default: ss_ticks = `BPS_TW'(`BPS_US2TICK(`BPS_SS3_US));
    endcase
  end

  // Hiccup wait in ticks, n = base index plus selection
  assign hic_wait = (`BPS_TW'(1) << (`BPS_HIC_N0 + ss_sel_q))
                    + `BPS_TW'(`BPS_HIC_BASE);

  // Shutdown causes
  assign shut   = ~sense.enable | sense.bias_lockout;
  assign hot    = sense.over_temp;
  assign ov_any = sense.overvoltage_protect | sense.backup_overvoltage_sense;

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    case (state)
      BPS_IDLE:
      begin
        next_state = BPS_SOFT;
      end
      BPS_SOFT:
      begin
        if (ov_any)
          next_state = BPS_OVCLAMP;
        else if (tick && tmr == ss_ticks - `BPS_TW'(1))
          next_state = BPS_RUN;
      end
      BPS_RUN:
      begin
        if (ov_any)
          next_state = BPS_OVCLAMP;
        else if (uv_trip)
          next_state = BPS_UVOFF;
      end
      BPS_OVCLAMP:
      begin
        if (rov_src && sense.undervoltage_protect)
          next_state = BPS_LATCHED;
        else if (!rov_src && uv_trip)
          next_state = BPS_LATCHED;
      end
      BPS_UVOFF:
      begin
        if (tick && tmr == hic_wait - `BPS_TW'(1)
            && reps == 3'(`BPS_HIC_REPS - 1))
          next_state = BPS_SOFT;
      end
      BPS_LATCHED:
      begin
        next_state = BPS_LATCHED;
      end
      default:
      begin
        next_state = BPS_IDLE;
      end
    endcase
    // Non-latching shutdowns take priority, over-temperature except in BPS_LATCHED
    if (shut)
      next_state = BPS_IDLE;
    else if (hot && state != BPS_LATCHED)
      next_state = BPS_IDLE;
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      state <= BPS_IDLE;
    else
      state <= next_state;
  end

  // Soft-start selection and overvoltage source capture
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ss_sel_q <= 2'h0;
      rov_src  <= 1'b0;
    end
    else
    begin
      if (state == BPS_IDLE)
        ss_sel_q <= sense.ss_sel;
      if (next_state == BPS_OVCLAMP && state != BPS_OVCLAMP)
        rov_src <= sense.backup_overvoltage_sense
                   & ~sense.overvoltage_protect;
    end
  end

  // Ramp and hiccup timer, seven waits make one delay
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tmr  <= '0;
      reps <= 3'h0;
    end
    else if (next_state != state)
    begin
      tmr  <= '0;
      reps <= 3'h0;
    end
    else if (tick && state == BPS_UVOFF)
    begin
      if (tmr == hic_wait - `BPS_TW'(1))
      begin
        tmr  <= '0;
        reps <= reps + 3'h1;
      end
      else
        tmr <= tmr + `BPS_TW'(1);
    end
    else if (tick && state == BPS_SOFT)
      tmr <= tmr + `BPS_TW'(1);
  end

  // Undervoltage arming after soft-start
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      uv_arm_cnt <= '0;
    else if (state != BPS_RUN)
      uv_arm_cnt <= '0;
    else if (tick && !uv_armed)
      uv_arm_cnt <= uv_arm_cnt + `BPS_TW'(1);
  end

  assign uv_armed = (uv_arm_cnt == `BPS_TW'(`BPS_UV_EN_TICKS));

  // Undervoltage delay counter
  assign uv_cond = sense.undervoltage_protect
                   & ((state == BPS_RUN & uv_armed)
                      | (state == BPS_OVCLAMP & ~rov_src));
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      uv_cnt <= '0;
    else if (!uv_cond)
      uv_cnt <= '0;
    else if (tick && !uv_trip)
      uv_cnt <= uv_cnt + `BPS_TW'(1);
  end

  assign uv_trip = uv_cond & (uv_cnt == `BPS_TW'(`BPS_UV_DLY_TICKS));

  // Power-good qualification and drop timers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pg_on_cnt  <= '0;
      pg_off_cnt <= '0;
      power_good <= 1'b0;
    end
    else if (state != BPS_RUN)
    begin
      pg_on_cnt  <= '0;
      pg_off_cnt <= '0;
      power_good <= 1'b0;
    end
    else if (!power_good)
    begin
      pg_off_cnt <= '0;
      if (!sense.win_good)
        pg_on_cnt <= '0;
      else if (pg_on_cnt == `BPS_TW'(`BPS_PG_ON_TICKS))
        power_good <= 1'b1;
      else if (tick)
        pg_on_cnt <= pg_on_cnt + `BPS_TW'(1);
    end
    else
    begin
      pg_on_cnt <= '0;
      if (!sense.win_bad)
        pg_off_cnt <= '0;
      else if (pg_off_cnt == `BPS_TW'(`BPS_PG_OFF_CYC - 1))
        power_good <= 1'b0;
      else
        pg_off_cnt <= pg_off_cnt + `BPS_TW'(1);
    end
  end

  // Open-drain pin: pulls low unless good
  assign power_ok_out_o  = 1'b0;
  assign power_ok_out_oe = ~power_good;

  // Switching permitted only in ramp and run
  assign run_ok      = (state == BPS_SOFT || state == BPS_RUN)
                       & ~shut & ~hot & ~ov_any;
  assign skip_active = run_ok & sense.skip_mode;

  // Gate decisions
  always_comb
  begin
    next_hs = 1'b0;
    next_ls = 1'b0;
    if (state == BPS_OVCLAMP && !shut && !hot)
    begin
      next_hs = 1'b0;
      next_ls = 1'b1;
    end
    else if (run_ok)
    begin
      // Valley overcurrent blocks a new on period
      next_hs = mod_req.hs_req
                & (gate.hs_drive | ~sense.overcurrent_protect);
      next_ls = mod_req.ls_req & ~next_hs & ~zc_hold;
    end
  end

  // Gate drive and discharge registers, one process owns the whole bundle
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gate.hs_drive  <= 1'b0;
      gate.ls_drive  <= 1'b0;
      gate.discharge <= 1'b0;
      en_prev        <= 1'b0;
    end
    else
    begin
      gate.hs_drive <= next_hs;
      gate.ls_drive <= next_ls;
      en_prev       <= sense.enable;
      // Discharge armed only by an enable fall, held while bias present
      if (sense.enable || sense.bias_lockout)
        gate.discharge <= 1'b0;
      else if (en_prev)
        gate.discharge <= 1'b1;
    end
  end

  // Status flags
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      soft_start_done <= 1'b0;
      ovp_latched     <= 1'b0;
    end
    else
    begin
      soft_start_done <= (next_state == BPS_RUN);
      ovp_latched     <= (next_state == BPS_LATCHED);
    end
  end

  // Adaptive zero-crossing retiming
  bps_zc_adapt u_zc (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .skip_active (skip_active),
    .zc_seen     (sense.zero_cross),
    .hs_on       (gate.hs_drive),
    .sw_late     (sense.sw_late),
    .sw_early    (sense.sw_early),
    .zc_hold     (zc_hold),
    .zc_code     (zc_code)
  );

endmodule

// File: sim/bps_sequencer_sva.sv
// Purpose: Port-level assertions of the buck protection sequencer
// Assumes: Bound to the top module, one clock domain
// Notes:   State-based gate checks allow one cycle for the registered drives
`timescale 1ns/1ps
module bps_sequencer_sva
  import bps_pkg::*;
#(
  parameter int P_TICK_CYC = 800
) (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_b,
  // Watched ports
  input wire bps_sense_t sense_in,
  input wire bps_gate_t  gate,
  input wire logic       power_ok_out_o,
  input wire logic       power_ok_out_oe,
  input wire bps_state_t state,
  input wire logic       soft_start_done,
  input wire logic       uv_armed,
  input wire logic       ovp_latched
);
  logic [19:0] good_cnt;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // Settled states, held two cycles, and the hiccup exit
  sequence s_clamp;
    state == BPS_OVCLAMP [*2];
  endsequence
  sequence s_latch;
    state == BPS_LATCHED [*2];
  endsequence
  sequence s_idle;
    state == BPS_IDLE [*2];
  endsequence
  sequence s_not_run;
    state != BPS_RUN [*2];
  endsequence
  sequence s_uv_leave;
    state == BPS_UVOFF ##1 state != BPS_UVOFF;
  endsequence

  // Cycles of continuous window-good flag
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      good_cnt <= '0;
    else if (!sense_in.win_good)
      good_cnt <= '0;
    else if (good_cnt != 20'hFFFFF)
      good_cnt <= good_cnt + 20'h1;
  end

  a_clamp_gates: assert property (s_clamp |-> !gate.hs_drive && gate.ls_drive)
    else $error("clamp gates wrong");
  a_latch_gates: assert property (s_latch |-> !gate.hs_drive && !gate.ls_drive)
    else $error("latched gates not off");
  a_latch_flag: assert property (s_latch |-> ovp_latched)
    else $error("latch flag missing");
  a_idle_gates: assert property (s_idle |-> !gate.hs_drive && !gate.ls_drive)
    else $error("idle gates not off");
  a_pg_idle: assert property (s_not_run |-> power_ok_out_oe)
    else $error("power good released outside run");
  a_pg_open: assert property (power_ok_out_o == 1'b0)
    else $error("power good pin driven high");
  a_pg_delay: assert property ($fell(power_ok_out_oe) |-> good_cnt >= 20'(249 * P_TICK_CYC))
    else $error("power good released too early");
  a_dis_gates: assert property (gate.discharge |-> !gate.hs_drive && !gate.ls_drive)
    else $error("gates on during discharge");
  a_dis_cause: assert property ($rose(gate.discharge) |-> !$past(sense_in.enable, 3))
    else $error("discharge without enable low");
  a_uv_arm: assert property ($rose(uv_armed) |-> state == BPS_RUN)
    else $error("undervoltage armed outside run");
  a_ss_done: assert property (soft_start_done |-> state == BPS_RUN || $past(state) == BPS_RUN)
    else $error("soft start done outside run");
  a_oc_hold: assert property ($rose(gate.hs_drive) |-> !($past(sense_in.overcurrent_protect, 1)
    && $past(sense_in.overcurrent_protect, 2) && $past(sense_in.overcurrent_protect, 3)))
    else $error("high side started in overcurrent");
  a_uv_exit: assert property (s_uv_leave |-> state inside {BPS_SOFT, BPS_IDLE})
    else $error("hiccup exit not to soft start");
endmodule

// File: sim/bps_stage_model.sv
// Purpose: Power-good pull-up and window comparators on the output level
// Assumes: Output level given by the bench in percent of target
// Notes:   Power-good line has an external pull-up
`timescale 1ns/1ps
module bps_stage_model (
  // Output level and pin enable
  input  wire logic [7:0] vout_pct,
  input  wire logic       pg_oe,
  // Pin level and comparator flags
  output logic            pg_pin,
  output logic            uv_flag,
  output logic            ov_flag,
  output logic            good,
  output logic            bad
);
  // Pull-up wins while the pin is released
  assign pg_pin = pg_oe ? 1'b0 : 1'b1;
  // Comparators on the output level
  assign uv_flag = vout_pct < 8'h46;
  assign ov_flag = vout_pct > 8'h78;
  assign good = (vout_pct >= 8'h5F) && (vout_pct <= 8'h6E);
  assign bad = (vout_pct < 8'h5A) || (vout_pct > 8'h73);
endmodule

// File: sim/test_buck_protection_sequencer.sv
// Purpose: Self-checking bench of the buck protection sequencer
// Assumes: Tick shortened to 8 cycles, stage model on the far side
// Notes:   Driver notes expectations, a monitor compares them
`timescale 1ns/1ps
`include "bps_defs.svh"
module test_buck_protection_sequencer;
  import bps_pkg::*;
  localparam int TC  = 8;
  localparam int HIC = 7 * ((1 << `BPS_HIC_N0) + `BPS_HIC_BASE) * TC;
  // Stimulus
  logic                 clk_sys = 1'b0;
  logic                 rst_b = 1'b0;
  logic                 en = 1'b0;
  logic                 lock = 1'b0;
  logic                 hot = 1'b0;
  logic                 bov = 1'b0;
  logic                 oc = 1'b0;
  logic                 hs_fix = 1'b0;
  logic                 rnd_on = 1'b0;
  logic [1:0]           ss = 2'h0;
  logic [7:0]           vout = 8'h64;
  logic [2:0]           rnd = 3'h0;
  bps_mod_t             mod_req = '0;
  bps_sense_t           sense_in;
  // Outputs and bookkeeping
  bps_gate_t            gate;
  bps_state_t           state;
  logic                 pg_oe, pg_pin, uv_f, ov_f, good_f, bad_f, uv_armed, ovp_latched;
  logic                 ss_done, len_ok;
  logic [`BPS_ZC_W-1:0] zc_code;
  logic [7:0]           obs [8];
  logic [7:0]           q_val [$];
  int                   q_id [$];
  int                   errors = 0;
  int                   n_checks = 0;
  int                   id, k, n;
  string nm [8] = '{"state", "hs", "ls", "discharge", "pg_pin", "latched", "soft_len", "zc"};

  assign sense_in = {en, lock, hot, uv_f, ov_f, bov, oc, rnd[0], good_f, bad_f, rnd[1], rnd[2],
                     1'b1, ss};
  always_comb obs = '{8'(state), 8'(gate.hs_drive), 8'(gate.ls_drive), 8'(gate.discharge),
                      8'(pg_pin), 8'(ovp_latched), 8'(len_ok), 8'(zc_code)};
  always #2.5 clk_sys = ~clk_sys;

  bps_sequencer #(.P_TICK_CYC(TC)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .sense_in(sense_in),
    .mod_req(mod_req), .gate(gate), .power_ok_out_i(pg_pin), .power_ok_out_o(),
    .power_ok_out_oe(pg_oe), .state(state), .soft_start_done(ss_done), .uv_armed(uv_armed),
    .ovp_latched(ovp_latched), .zc_code(zc_code));
  bps_stage_model u_stage (.vout_pct(vout), .pg_oe(pg_oe), .pg_pin(pg_pin), .uv_flag(uv_f),
    .ov_flag(ov_f), .good(good_f), .bad(bad_f));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s exp %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic note(input int i, input logic [7:0] v);
    q_id.push_back(i);
    q_val.push_back(v);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge clk_sys);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Bounded wait for a state, then note it
  task automatic wait_st(input bps_state_t s, input int bound);
    for (int i = 0; i < bound && state !== s; i++)
      cyc(1);
    if (state !== s)
    begin
      errors++;
      $display("BAD wait exp %0h seen %0h", s, state);
      report_and_stop();
    end
    else
      note(0, 8'(s));
  endtask

  // Compare notes once the outputs have settled
  always @(negedge clk_sys)
  begin
    #1;
    while (q_id.size() > 0)
    begin
      id = q_id.pop_front();
      check(nm[id], obs[id], q_val.pop_front());
    end
  end

  // Random modulator requests and zero-cross activity
  initial
  begin
    void'($urandom(32'hd18d));
    forever
    begin
      @(negedge clk_sys);
      rnd <= rnd_on ? 3'($urandom) : 3'h0;
      mod_req <= rnd_on ? bps_mod_t'(2'($urandom)) : bps_mod_t'({hs_fix, 1'b0});
    end
  end

  // Main sequence
  initial
  begin
    cyc(4);
    rst_b = 1'b1;
    cyc(1);
    note(0, 8'(BPS_IDLE));
    note(4, 8'h00);
    note(7, 8'h04);
    en = 1'b1;
    rnd_on = 1'b1;
    for (k = 3; k >= 0; k--)
    begin
      ss = 2'(k);
      wait_st(BPS_SOFT, 20);
      note(4, 8'h00);
      for (n = 0; state === BPS_SOFT && n < 12000; n++)
        cyc(1);
      len_ok = (n + TC >= (175 << k) * TC) && (n <= ((175 << k) + 1) * TC + 4);
      note(6, 8'h01);
      note(0, 8'(BPS_RUN));
      if (k > 0)
      begin
        en = 1'b0;
        wait_st(BPS_IDLE, 10);
        cyc(4);
        note(3, 8'h01);
        en = 1'b1;
      end
    end
    cyc(240 * TC);
    note(4, 8'h00);
    cyc(20 * TC);
    note(4, 8'h01);
    vout = 8'h58;
    cyc(390);
    note(4, 8'h01);
    cyc(30);
    note(4, 8'h00);
    vout = 8'h64;
    rnd_on = 1'b0;
    cyc(4);
    oc = 1'b1;
    cyc(4);
    hs_fix = 1'b1;
    for (n = 0; n < 20; n++)
    begin
      cyc(1);
      note(1, 8'h00);
    end
    oc = 1'b0;
    cyc(6);
    note(1, 8'h01);
    hs_fix = 1'b0;
    rnd_on = 1'b1;
    vout = 8'h32;
    wait_st(BPS_UVOFF, 400 * TC);
    cyc(1);
    note(1, 8'h00);
    note(2, 8'h00);
    cyc(HIC - 4 * TC);
    note(0, 8'(BPS_UVOFF));
    wait_st(BPS_SOFT, 8 * TC);
    wait_st(BPS_RUN, 180 * TC);
    cyc(600 * TC);
    note(0, 8'(BPS_RUN));
    wait_st(BPS_UVOFF, 40 * TC);
    en = 1'b0;
    wait_st(BPS_IDLE, 10);
    vout = 8'h64;
    en = 1'b1;
    wait_st(BPS_RUN, 200 * TC);
    vout = 8'h7D;
    wait_st(BPS_OVCLAMP, 10);
    cyc(2);
    note(1, 8'h00);
    note(2, 8'h01);
    vout = 8'h32;
    wait_st(BPS_LATCHED, 260 * TC);
    cyc(2);
    note(2, 8'h00);
    note(5, 8'h01);
    en = 1'b0;
    wait_st(BPS_IDLE, 10);
    cyc(4);
    note(3, 8'h01);
    lock = 1'b1;
    cyc(6);
    note(3, 8'h00);
    en = 1'b1;
    cyc(10);
    note(0, 8'(BPS_IDLE));
    lock = 1'b0;
    vout = 8'h64;
    wait_st(BPS_SOFT, 10);
    wait_st(BPS_RUN, 200 * TC);
    bov = 1'b1;
    wait_st(BPS_OVCLAMP, 10);
    vout = 8'h32;
    wait_st(BPS_LATCHED, 10);
    bov = 1'b0;
    en = 1'b0;
    wait_st(BPS_IDLE, 10);
    vout = 8'h64;
    en = 1'b1;
    wait_st(BPS_SOFT, 10);
    hot = 1'b1;
    wait_st(BPS_IDLE, 10);
    hot = 1'b0;
    wait_st(BPS_SOFT, 10);
    cyc(2);
    report_and_stop();
  end
endmodule

bind bps_sequencer bps_sequencer_sva #(.P_TICK_CYC(P_TICK_CYC)) u_sva (.clk_sys(clk_sys),
  .rst_b(rst_b), .sense_in(sense_in), .gate(gate), .power_ok_out_o(power_ok_out_o),
  .power_ok_out_oe(power_ok_out_oe), .state(state), .soft_start_done(soft_start_done),
  .uv_armed(uv_armed), .ovp_latched(ovp_latched));
